// ---- include/gcmf_params.svh ----
`ifndef GCMF_PARAMS_SVH
`define GCMF_PARAMS_SVH

// ==========================================================
// Timing counts, in cycles of the old (off) and newly selected (on) input clock
`define GCMF_OFF_CYCLES     3
`define GCMF_ON_CYCLES      3
`define GCMF_CNT_W          2
`define GCMF_SYNC_STAGES    2
`define GCMF_NUM_OUTPUTS    4
`define GCMF_SEL_SECOND     1'h0
`define GCMF_SEL_FIRST      1'h1

// ==========================================================
// Output levels
`define GCMF_Q_TRUE_RST     4'h0
`define GCMF_Q_COMP_RST     4'hF
`define GCMF_PD_LEVEL       4'hF
`endif

// ---- include/gcmf_pkg.sv ----
package gcmf_pkg;
  typedef enum logic [1:0] {
    GCMF_RUN,
    GCMF_STOP_OLD,
    GCMF_WAKE_NEW
  } gcmf_state_t;

  typedef struct packed {
    logic       sel;
    logic       forced_choice_edge;
    logic       gate;
    logic       gated_level;
    logic       power_down_n;
  } gcmf_ctrl_t;

  typedef struct packed {
    logic [3:0] q_true;
    logic [3:0] q_comp;
  } gcmf_out_t;
endpackage

// ---- hdl/gcmf_sync.sv ----
`timescale 1ns/100ps
`include "gcmf_params.svh"
module gcmf_sync
  import gcmf_pkg::*;
#(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q      = stage1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= next_stage1;
      q      <= next_q;
    end
  end
endmodule // gcmf_sync

// ---- hdl/gcmf_top.sv ----
`timescale 1ns/100ps
`include "gcmf_params.svh"
module gcmf_top
  import gcmf_pkg::*;
(
  // System
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // Clock inputs
  input  wire logic       CLOCK_IN_FIRST,
  input  wire logic       CLOCK_IN_SECOND,
  // Controls
  input  wire logic       SEL,
  input  wire logic       FORCED_CHOICE_EDGE,
  input  wire logic       GATE,
  input  wire logic       GATED_LEVEL,
  input  wire logic       POWER_DOWN_N,
  // Outputs
  output logic      [3:0] Q_TRUE,
  output logic      [3:0] Q_COMP
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] raw_clk;
  logic [1:0] syn_clk;
  logic [4:0] raw_ctrl;
  logic [4:0] syn_ctrl;
  gcmf_ctrl_t ctrl;
  logic       a1;
  logic       a2;

  assign raw_clk  = {CLOCK_IN_FIRST, CLOCK_IN_SECOND};
  // Power-down carried inverted: sync reset value reads as running
  assign raw_ctrl = {SEL, FORCED_CHOICE_EDGE, GATE, GATED_LEVEL, !POWER_DOWN_N};

  // Clock and control paths kept apart for separate timing constraints
  gcmf_sync #(.W(2)) u_sync_clk (
    .clk    (CLK),
    .resetn (RESETN),
    .d      (raw_clk),
    .q      (syn_clk)
  );

  gcmf_sync #(.W(5)) u_sync_ctrl (
    .clk    (CLK),
    .resetn (RESETN),
    .d      (raw_ctrl),
    .q      (syn_ctrl)
  );

  assign a1   = syn_clk[1];
  assign a2   = syn_clk[0];
  assign ctrl = {syn_ctrl[4:1], !syn_ctrl[0]};

  function automatic logic pick(input logic s, input logic f, input logic c);
    pick = (s == `GCMF_SEL_FIRST) ? f : c;
  endfunction

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur && !prev;
  endfunction

  // ==========================================================
  // Edge detection on the synchronised inputs
  logic       a1_d;
  logic       a2_d;
  logic       next_a1_d;
  logic       next_a2_d;

  always_comb begin
    next_a1_d = a1;
    next_a2_d = a2;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      a1_d <= 1'b0;
      a2_d <= 1'b0;
    end else begin
      a1_d <= next_a1_d;
      a2_d <= next_a2_d;
    end
  end

  // ==========================================================
  // Changeover control
  gcmf_state_t                 state;
  gcmf_state_t                 next_state;
  logic                        cur_sel;
  logic                        next_cur_sel;
  logic                        old_sel;
  logic                        next_old_sel;
  logic [`GCMF_CNT_W-1:0]      cnt;
  logic [`GCMF_CNT_W-1:0]      next_cnt;
  logic                        fce_d;
  logic                        next_fce_d;
  logic                        pass;
  logic                        next_pass;
  logic                        fce_rise;
  logic                        old_rise;
  logic                        new_rise;
  logic                        cur_clk;
  logic                        drive_sel;

  always_comb begin
    fce_rise  = rise(ctrl.forced_choice_edge, fce_d);
    old_rise  = pick(old_sel, rise(a1, a1_d), rise(a2, a2_d));
    new_rise  = pick(cur_sel, rise(a1, a1_d), rise(a2, a2_d));
    // Old clock keeps the pins until caught low, else a runt escapes
    drive_sel = (state == GCMF_STOP_OLD) ? old_sel : cur_sel;
    cur_clk   = pick(drive_sel, a1, a2);
    next_state   = state;
    next_cur_sel = cur_sel;
    next_old_sel = old_sel;
    next_cnt     = cnt;
    next_pass    = pass;
    next_fce_d   = ctrl.forced_choice_edge;
    if (fce_rise) begin
      // Forced choice bypasses the old-clock wait; it may be dead
      next_state   = GCMF_WAKE_NEW;
      next_cur_sel = ctrl.sel;
      next_pass    = 1'b0;
      next_cnt     = '0;
    end else begin
      case (state)
        GCMF_RUN: begin
          if (ctrl.sel != cur_sel) begin
            next_state   = GCMF_STOP_OLD;
            next_old_sel = cur_sel;
            next_cur_sel = ctrl.sel;
            next_cnt     = '0;
          end
        end
        GCMF_STOP_OLD: begin
          // Drop only while old clock is low, so no runt high pulse
          if (!pick(old_sel, a1, a2)) begin
            next_pass = 1'b0;
          end
          if (old_rise) begin
            if (cnt == 2'(`GCMF_OFF_CYCLES - 1)) begin
              next_state = GCMF_WAKE_NEW;
              next_pass  = 1'b0;
              next_cnt   = '0;
            end else begin
              next_cnt = cnt + 2'h1;
            end
          end
        end
        GCMF_WAKE_NEW: begin
          if (new_rise) begin
            if (cnt == 2'(`GCMF_ON_CYCLES - 1)) begin
              next_state = GCMF_RUN;
              next_cnt   = '0;
            end else begin
              next_cnt = cnt + 2'h1;
            end
          end
          // Resume on the new rise; first high phase loses one sample
          if (state == GCMF_WAKE_NEW && cnt == 2'(`GCMF_ON_CYCLES - 1)
              && new_rise) begin
            next_pass = 1'b1;
          end
        end
        default: begin
          next_state = GCMF_RUN;
          next_pass  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state   <= GCMF_RUN;
      cur_sel <= `GCMF_SEL_SECOND;
      old_sel <= `GCMF_SEL_SECOND;
      cnt     <= '0;
      fce_d   <= 1'b0;
      pass    <= 1'b1;
    end else begin
      state   <= next_state;
      cur_sel <= next_cur_sel;
      old_sel <= next_old_sel;
      cnt     <= next_cnt;
      fce_d   <= next_fce_d;
      pass    <= next_pass;
    end
  end

  // ==========================================================
  // Output stage
  gcmf_out_t next_out;

  always_comb begin
    if (!ctrl.power_down_n) begin
      next_out.q_true = `GCMF_PD_LEVEL;
      next_out.q_comp = `GCMF_PD_LEVEL;
    end else if (ctrl.gate) begin
      next_out.q_true = {4{ctrl.gated_level}};
      next_out.q_comp = {4{!ctrl.gated_level}};
    end else begin
      // Gate not tied to clock phase: runt pulses are the user's problem
      next_out.q_true = {4{cur_clk && pass}};
      next_out.q_comp = {4{!(cur_clk && pass)}};
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      Q_TRUE <= `GCMF_Q_TRUE_RST;
      Q_COMP <= `GCMF_Q_COMP_RST;
    end else begin
      Q_TRUE <= next_out.q_true;
      Q_COMP <= next_out.q_comp;
    end
  end
endmodule // gcmf_top

// ---- verif/gcmf_checker.sv ----
`timescale 1ns/100ps
module gcmf_checker (
  // System
  input wire logic       CLK,
  input wire logic       RESETN,
  // Pins
  input wire logic       CLOCK_IN_FIRST,
  input wire logic       CLOCK_IN_SECOND,
  input wire logic       SEL,
  input wire logic       FORCED_CHOICE_EDGE,
  input wire logic       GATE,
  input wire logic       GATED_LEVEL,
  input wire logic       POWER_DOWN_N,
  input wire logic [3:0] Q_TRUE,
  input wire logic [3:0] Q_COMP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic [6:0] calm, next_calm;
  logic [3:0] held, next_held;
  logic [2:0] prev, next_prev;
  wire        chosen = SEL ? CLOCK_IN_FIRST : CLOCK_IN_SECOND;
  // =====================================
  // Quiet time, so passing is judged only after a changeover ends
  always_comb begin
    next_prev = {SEL, GATE, POWER_DOWN_N};
    next_calm = (next_prev != prev || FORCED_CHOICE_EDGE) ? 7'h00 : calm + {6'h00, calm != 7'h7F};
    next_held = (next_prev[1:0] != prev[1:0]) ? 4'h0 : held + {3'h0, held != 4'hF};
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      calm <= 7'h00;
      held <= 4'h0;
      prev <= 3'h1;
    end else begin
      calm <= next_calm;
      held <= next_held;
      prev <= next_prev;
    end
  end
  // =====================================
  property p_pd; !$past(POWER_DOWN_N, 3) |-> Q_TRUE == 4'hF && Q_COMP == 4'hF; endproperty
  a_pd: assert property (p_pd) else $error("power-down level wrong");
  property p_gate;
    $past(POWER_DOWN_N, 3) && $past(GATE, 3) |-> Q_TRUE == {4{$past(GATED_LEVEL, 3)}};
  endproperty
  a_gate: assert property (p_gate) else $error("gated level wrong");
  property p_comp; $past(POWER_DOWN_N, 3) |-> Q_COMP == ~Q_TRUE; endproperty
  a_comp: assert property (p_comp) else $error("pair not complementary");
  property p_fan; Q_TRUE == {4{Q_TRUE[0]}}; endproperty
  a_fan: assert property (p_fan) else $error("outputs differ");
  property p_pass; calm == 7'h7F && !GATE |-> Q_TRUE[0] == $past(chosen, 3); endproperty
  a_pass: assert property (p_pass) else $error("selected clock not passed");
  property p_off; $changed(SEL) && POWER_DOWN_N && !GATE |-> ##[1:40] (Q_TRUE == 4'h0) [*8];
  endproperty
  a_off: assert property (p_off) else $error("no low gap on change");
  property p_force; $rose(FORCED_CHOICE_EDGE) && !GATE |-> ##[2:8] (Q_TRUE == 4'h0) [*8];
  endproperty
  a_force: assert property (p_force) else $error("forced change not taken");
  property p_glitch; held == 4'hF && $rose(Q_TRUE[0]) |=> Q_TRUE[0] [*2]; endproperty
  a_glitch: assert property (p_glitch) else $error("runt pulse");
  c_off: cover property ($changed(SEL));
  c_force: cover property ($rose(FORCED_CHOICE_EDGE));
  c_pd: cover property (!POWER_DOWN_N);
endmodule // gcmf_checker

bind gcmf_top gcmf_checker u_chk (.CLK(CLK), .RESETN(RESETN), .CLOCK_IN_FIRST(CLOCK_IN_FIRST),
  .CLOCK_IN_SECOND(CLOCK_IN_SECOND), .SEL(SEL), .FORCED_CHOICE_EDGE(FORCED_CHOICE_EDGE),
  .GATE(GATE), .GATED_LEVEL(GATED_LEVEL), .POWER_DOWN_N(POWER_DOWN_N), .Q_TRUE(Q_TRUE),
  .Q_COMP(Q_COMP));

// ---- verif/gcmf_src_model.sv ----
`timescale 1ns/100ps
module gcmf_src_model #(
  parameter realtime HALF = 100.0,
  parameter realtime LAG  = 0.0
) (
  // Control
  input  wire logic run,
  // Clock
  output logic      clk_out
);
  initial begin
    clk_out = 1'b0;
    #(LAG);
    forever begin
      #(HALF);
      // A dead source parks low after its last high phase
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule // gcmf_src_model

// ---- verif/glitchless_clock_mux_fanout_tb_top.sv ----
`timescale 1ns/100ps
module glitchless_clock_mux_fanout_tb_top;
  import gcmf_pkg::*;
  logic      CLK = 0, RESETN = 0, SEL = 0, FORCED_CHOICE_EDGE = 0, GATE = 0, GATED_LEVEL = 0;
  logic      POWER_DOWN_N = 1, run_a = 1, run_b = 1, rb;
  logic      CLOCK_IN_FIRST, CLOCK_IN_SECOND;
  wire gcmf_out_t q;
  gcmf_out_t exp_q[$];
  bit        mq[$];
  int        err_count = 0;
  int        checks = 0;
  integer    seed = 32'heae89080;
  event      smp;
  localparam gcmf_out_t ACT = 8'hFF;
  localparam gcmf_out_t STUCK = 8'h0F;

  always #12.5 CLK = ~CLK;
  gcmf_src_model #(.HALF(100.0), .LAG(0.0)) u_src_first (.run(run_a), .clk_out(CLOCK_IN_FIRST));
  gcmf_src_model #(.HALF(100.0), .LAG(37.0)) u_src_second (.run(run_b), .clk_out(CLOCK_IN_SECOND));
  gcmf_top u_gcmf_top (.CLK(CLK), .RESETN(RESETN), .CLOCK_IN_FIRST(CLOCK_IN_FIRST),
    .CLOCK_IN_SECOND(CLOCK_IN_SECOND), .SEL(SEL), .FORCED_CHOICE_EDGE(FORCED_CHOICE_EDGE),
    .GATE(GATE), .GATED_LEVEL(GATED_LEVEL), .POWER_DOWN_N(POWER_DOWN_N),
    .Q_TRUE(q.q_true), .Q_COMP(q.q_comp));

  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input gcmf_out_t e, input gcmf_out_t g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Note an expectation; activity means both levels seen on the outputs
  task automatic note(input bit act, input gcmf_out_t e);
    int n;
    repeat (6) @(negedge CLK);
    exp_q.push_back(e);
    mq.push_back(act);
    -> smp;
    n = 0;
    while (exp_q.size() != 0 && n < 100) begin
      @(negedge CLK);
      n++;
    end
    if (n == 100) begin
      err_count++;
      report_and_stop();
    end
  endtask

  always @(smp) begin : mon
    gcmf_out_t got;
    got = '0;
    if (mq.pop_front()) begin
      repeat (40) begin
        @(negedge CLK);
        if (q.q_true === 4'hF && q.q_comp === 4'h0) got.q_true = 4'hF;
        if (q.q_true === 4'h0 && q.q_comp === 4'hF) got.q_comp = 4'hF;
      end
    end else got = q;
    cmp(exp_q.pop_front(), got);
  end

  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(negedge CLK);
    RESETN = 1'b1;
    note(1'b1, ACT);
    run_b = 1'b0;
    note(1'b1, STUCK);
    run_b = 1'b1;
    SEL = 1'b1;
    repeat (100) @(negedge CLK);
    run_b = 1'b0;
    note(1'b1, ACT);
    run_a = 1'b0;
    run_b = 1'b1;
    SEL = 1'b0;
    repeat (20) @(negedge CLK);
    FORCED_CHOICE_EDGE = 1'b1;
    repeat (4) @(negedge CLK);
    FORCED_CHOICE_EDGE = 1'b0;
    repeat (150) @(negedge CLK);
    note(1'b1, ACT);
    run_a = 1'b1;
    rb = 1'($random(seed));
    for (int i = 0; i < 4; i++) begin
      GATED_LEVEL = rb ^ i[0];
      GATE = 1'b1;
      note(1'b0, {{4{GATED_LEVEL}}, {4{~GATED_LEVEL}}});
    end
    // Gated first so the loads see no runt on the way down
    POWER_DOWN_N = 1'b0;
    note(1'b0, 8'hFF);
    POWER_DOWN_N = 1'b1;
    note(1'b0, {{4{GATED_LEVEL}}, {4{~GATED_LEVEL}}});
    GATE = 1'b0;
    note(1'b1, ACT);
    report_and_stop();
  end
endmodule // glitchless_clock_mux_fanout_tb_top
